// [common/fnd_pkg.sv]
// Shared constants and types for the fractional-N feedback divider
package fnd_pkg;
  localparam int unsigned INT_W = 16;
  localparam int unsigned FRAC_W = 16;
  localparam int unsigned REFDIV_W = 10;
  localparam int unsigned BSDIV_W = 12;
  localparam logic [2:0] ADDR_W0 = 3'h0;
  localparam logic [2:0] ADDR_W1 = 3'h1;
  localparam logic [2:0] ADDR_W2 = 3'h2;
  localparam logic [2:0] ADDR_W4 = 3'h4;
  localparam logic [2:0] ADDR_W6 = 3'h6;
  localparam logic [2:0] ADDR_W7 = 3'h7;
  localparam int unsigned INT_LSB = 15;
  localparam int unsigned FRAC_LSB = 3;
  localparam int unsigned EXT_NUM_LSB = 0;
  localparam int unsigned MODULUS_EXTENSION_BITS_LSB = 4;
  localparam int unsigned EXT16_BIT = 8;
  localparam int unsigned DITHER_BIT = 9;
  localparam int unsigned REFDIV_LSB = 14;
  localparam int unsigned REFHALF_BIT = 24;
  localparam int unsigned DOUBLER_BIT = 25;
  localparam int unsigned LDW_LOW_BIT = 7;
  localparam int unsigned BSDIV_LSB = 12;
  localparam int unsigned PRI_EN_BIT = 5;
  localparam int unsigned AUX_EN_BIT = 6;
  localparam int unsigned BSEXT_LSB = 3;
  localparam int unsigned LDW_EXTL_BIT = 26;
  localparam int unsigned LDW_EXTH_BIT = 27;
  localparam logic [31:0] RST_W0 = 32'h0032_0000;
  localparam logic [31:0] RST_W1 = 32'h0000_0010;
  localparam logic [31:0] RST_W2 = 32'h0000_4000;
  localparam logic [31:0] RST_W4 = 32'h0001_0020;
  localparam logic [31:0] RST_WZ = 32'h0000_0000;
  localparam logic [20:0] LFSR_SEED = 21'h1ACE5;
  localparam int unsigned CAL_STEPS = 3;
  // Lock window in tenths of a ns per code
  localparam logic [6:0] LDW_TAB [0:7] = '{7'h64, 7'h3C, 7'h1E, 7'h1E,
                                          7'h28, 7'h2D, 7'h0F, 7'h0F};
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_DONE = 2'b11
  } fnd_cal_t;
endpackage

// [src/fnd_sdm.sv]
// First-order sigma-delta modulator with optional LFSR dither
`timescale 1ns/100ps
`default_nettype none
module fnd_sdm (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Control
  input wire logic step,
  input wire logic restart,
  input wire logic dither_en,
  input wire logic [15:0] numer,
  input wire logic [15:0] fraction_modulus,
  // Result
  output logic carry_r
);
  logic [16:0] acc_r, acc_nxt;
  logic [20:0] lfsr_r, lfsr_nxt;
  logic carry_nxt;
  logic [16:0] sum;

  always_comb begin
    acc_nxt = acc_r;
    lfsr_nxt = lfsr_r;
    carry_nxt = carry_r;
    // Dither adds one LSB on odd LFSR states; it averages out
    sum = acc_r + {1'b0, numer} + {16'h0000, dither_en & lfsr_r[0]};
    if (restart) begin
      acc_nxt = 17'h00000;
      lfsr_nxt = fnd_pkg::LFSR_SEED;
      carry_nxt = 1'b0;
    end else if (step) begin
      lfsr_nxt = {lfsr_r[19:0], lfsr_r[20] ^ lfsr_r[18]};
      if (sum >= {1'b0, fraction_modulus}) begin
        acc_nxt = sum - {1'b0, fraction_modulus};
        carry_nxt = 1'b1;
      end else begin
        acc_nxt = sum;
        carry_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_r <= 17'h00000;
      lfsr_r <= fnd_pkg::LFSR_SEED;
      carry_r <= 1'b0;
    end else if (clk_en) begin
      acc_r <= acc_nxt;
      lfsr_r <= lfsr_nxt;
      carry_r <= carry_nxt;
    end
  end

  a_acc_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fraction_modulus > 16'h0001 && numer < fraction_modulus && !dither_en)
    |=> acc_r < {1'b0, $past(fraction_modulus)})
    else $error("accumulator above modulus");
endmodule
`default_nettype wire

// [src/fnd_top.sv]
// Fractional-N feedback divider, reference path and calibration control
`timescale 1ns/100ps
`default_nettype none
module fnd_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Link pins; ref_in and vco_fb sampled on sys_clk, ref_dbl_edge unused
  input wire logic ref_in,
  input wire logic vco_fb,
  input wire logic ref_dbl_edge,
  // Results
  output logic ref_pulse,
  output logic fb_pulse,
  output logic band_clk,
  output logic [1:0] vco_band,
  output logic cal_busy,
  output logic [6:0] lock_window,
  output logic primary_rf_output,
  output logic auxiliary_rf_output
);
  logic [31:0] w0_r, w1_r, w2_r, w4_r, w6_r, w7_r;
  logic [31:0] w0_nxt, w1_nxt, w2_nxt, w4_nxt, w6_nxt, w7_nxt;
  logic [31:0] rdata_nxt;
  logic ref_q_r, fb_q_r;
  logic ref_rise, fb_rise, ref_ev;
  logic [9:0] rcnt_r, rcnt_nxt;
  logic rhalf_r, rhalf_nxt;
  logic ref_pulse_nxt;
  logic [16:0] ncnt_r, ncnt_nxt;
  logic fb_pulse_nxt;
  logic [11:0] bcnt_r, bcnt_nxt;
  logic band_clk_nxt;
  fnd_pkg::fnd_cal_t cal_r, cal_nxt;
  logic [1:0] band_r, band_nxt;
  logic [1:0] cstep_r, cstep_nxt;
  logic carry;
  logic [15:0] int_val, numer, fraction_modulus;
  logic [9:0] refdiv;
  logic [11:0] bsdiv;
  logic dither_en, ext16, w0_wr;
  logic [2:0] ldw_code;

  // Fields join a 12-bit base with 4 extension bits from another word when 16-bit mode is on
  function automatic logic [15:0] ext_field(input logic [11:0] base,
                                            input logic [3:0] ext,
                                            input logic wide);
    ext_field = wide ? {ext, base} : {4'h0, base};
  endfunction

  function automatic logic [9:0] at_least_one(input logic [9:0] v);
    at_least_one = (v == 10'h000) ? 10'h001 : v;
  endfunction

  assign int_val = w0_r[fnd_pkg::INT_LSB +: 16];
  assign ext16 = w7_r[fnd_pkg::EXT16_BIT];
  assign numer = ext_field(w0_r[fnd_pkg::FRAC_LSB +: 12],
    w7_r[fnd_pkg::EXT_NUM_LSB +: 4], ext16);
  assign fraction_modulus = ext_field(w1_r[fnd_pkg::FRAC_LSB +: 12],
    w7_r[fnd_pkg::MODULUS_EXTENSION_BITS_LSB +: 4], ext16);
  assign dither_en = w7_r[fnd_pkg::DITHER_BIT];
  assign refdiv = at_least_one(w2_r[fnd_pkg::REFDIV_LSB +: 10]);
  assign bsdiv = {w6_r[fnd_pkg::BSEXT_LSB +: 4],
    w4_r[fnd_pkg::BSDIV_LSB +: 8]};
  assign ldw_code = {w6_r[fnd_pkg::LDW_EXTH_BIT],
    w6_r[fnd_pkg::LDW_EXTL_BIT], w2_r[fnd_pkg::LDW_LOW_BIT]};
  assign lock_window = fnd_pkg::LDW_TAB[ldw_code];
  assign primary_rf_output = w4_r[fnd_pkg::PRI_EN_BIT];
  assign auxiliary_rf_output = w4_r[fnd_pkg::AUX_EN_BIT];
  assign w0_wr = reg_wr && reg_addr == fnd_pkg::ADDR_W0;
  assign vco_band = band_r;
  assign cal_busy = cal_r != fnd_pkg::CAL_DONE;

  // Register port
  always_comb begin
    w0_nxt = w0_r;
    w1_nxt = w1_r;
    w2_nxt = w2_r;
    w4_nxt = w4_r;
    w6_nxt = w6_r;
    w7_nxt = w7_r;
    if (reg_wr) begin
      case (reg_addr)
        fnd_pkg::ADDR_W0: w0_nxt = reg_wdata;
        fnd_pkg::ADDR_W1: w1_nxt = reg_wdata;
        fnd_pkg::ADDR_W2: w2_nxt = reg_wdata;
        fnd_pkg::ADDR_W4: w4_nxt = reg_wdata;
        fnd_pkg::ADDR_W6: w6_nxt = reg_wdata;
        fnd_pkg::ADDR_W7: w7_nxt = reg_wdata;
        default: w0_nxt = w0_r;
      endcase
    end
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        fnd_pkg::ADDR_W0: rdata_nxt = w0_r;
        fnd_pkg::ADDR_W1: rdata_nxt = w1_r;
        fnd_pkg::ADDR_W2: rdata_nxt = w2_r;
        // Word 3 reports calibration state instead of unused space
        3'h3: rdata_nxt = {28'h0000000, cal_busy, 1'b0, band_r};
        fnd_pkg::ADDR_W4: rdata_nxt = w4_r;
        fnd_pkg::ADDR_W6: rdata_nxt = w6_r;
        fnd_pkg::ADDR_W7: rdata_nxt = w7_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      w0_r <= fnd_pkg::RST_W0;
      w1_r <= fnd_pkg::RST_W1;
      w2_r <= fnd_pkg::RST_W2;
      w4_r <= fnd_pkg::RST_W4;
      w6_r <= fnd_pkg::RST_WZ;
      w7_r <= fnd_pkg::RST_WZ;
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      w0_r <= w0_nxt;
      w1_r <= w1_nxt;
      w2_r <= w2_nxt;
      w4_r <= w4_nxt;
      w6_r <= w6_nxt;
      w7_r <= w7_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // Reference path; doubler counts both edges of the reference
  assign ref_rise = ref_in && !ref_q_r;
  assign fb_rise = vco_fb && !fb_q_r;
  assign ref_ev = w2_r[fnd_pkg::DOUBLER_BIT] ? (ref_in != ref_q_r)
                                             : ref_rise;
  always_comb begin
    rcnt_nxt = rcnt_r;
    rhalf_nxt = rhalf_r;
    ref_pulse_nxt = 1'b0;
    if (ref_ev) begin
      if (rcnt_r >= refdiv - 10'h001) begin
        rcnt_nxt = 10'h000;
        // Halving swallows every other terminal count
        rhalf_nxt = w2_r[fnd_pkg::REFHALF_BIT] ? !rhalf_r : 1'b0;
        ref_pulse_nxt = !w2_r[fnd_pkg::REFHALF_BIT] || rhalf_r;
      end else begin
        rcnt_nxt = rcnt_r + 10'h001;
      end
    end
  end

  // Feedback counter; modulator carry stretches one period by one count
  always_comb begin
    ncnt_nxt = ncnt_r;
    fb_pulse_nxt = 1'b0;
    if (fb_rise) begin
      if (ncnt_r >= {1'b0, int_val} + {16'h0000, carry} - 17'h00001) begin
        ncnt_nxt = 17'h00000;
        fb_pulse_nxt = 1'b1;
      end else begin
        ncnt_nxt = ncnt_r + 17'h00001;
      end
    end
  end

  // Band-select clock divides the comparison rate
  always_comb begin
    bcnt_nxt = bcnt_r;
    // One-cycle tick; holding it high would step calibration every cycle
    band_clk_nxt = 1'b0;
    if (ref_pulse) begin
      if (bcnt_r >= bsdiv - 12'h001) begin
        bcnt_nxt = 12'h000;
        band_clk_nxt = 1'b1;
      end else begin
        bcnt_nxt = bcnt_r + 12'h001;
        band_clk_nxt = 1'b0;
      end
    end
  end

  // Calibration walks the three bands, one per band clock tick
  always_comb begin
    cal_nxt = cal_r;
    band_nxt = band_r;
    cstep_nxt = cstep_r;
    if (w0_wr) begin
      cal_nxt = fnd_pkg::CAL_RUN;
      band_nxt = 2'b00;
      cstep_nxt = 2'b00;
    end else begin
      case (cal_r)
        fnd_pkg::CAL_IDLE: cal_nxt = fnd_pkg::CAL_RUN;
        fnd_pkg::CAL_RUN: begin
          if (band_clk) begin
            band_nxt = cstep_r;
            cstep_nxt = cstep_r + 2'b01;
            if (cstep_r == 2'(fnd_pkg::CAL_STEPS - 1)) begin
              cal_nxt = fnd_pkg::CAL_DONE;
            end
          end
        end
        fnd_pkg::CAL_DONE: cal_nxt = fnd_pkg::CAL_DONE;
        default: cal_nxt = fnd_pkg::CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ref_q_r <= 1'b0;
      fb_q_r <= 1'b0;
      rcnt_r <= 10'h000;
      rhalf_r <= 1'b0;
      ref_pulse <= 1'b0;
      ncnt_r <= 17'h00000;
      fb_pulse <= 1'b0;
      bcnt_r <= 12'h000;
      band_clk <= 1'b0;
      cal_r <= fnd_pkg::CAL_IDLE;
      band_r <= 2'b00;
      cstep_r <= 2'b00;
    end else if (clk_en) begin
      ref_q_r <= ref_in;
      fb_q_r <= vco_fb;
      rcnt_r <= rcnt_nxt;
      rhalf_r <= rhalf_nxt;
      ref_pulse <= ref_pulse_nxt;
      ncnt_r <= ncnt_nxt;
      fb_pulse <= fb_pulse_nxt;
      bcnt_r <= bcnt_nxt;
      band_clk <= band_clk_nxt;
      cal_r <= cal_nxt;
      band_r <= band_nxt;
      cstep_r <= cstep_nxt;
    end
  end

  // Modulator steps once per feedback period
  fnd_sdm u_sdm (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .step(fb_pulse_nxt),
    .restart(w0_wr),
    .dither_en(dither_en),
    .numer(numer),
    .fraction_modulus(fraction_modulus),
    .carry_r(carry)
  );

  a_int_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    numer == 16'h0000 && !dither_en && !$past(w0_wr) |-> !carry)
    else $error("carry with zero numerator");
  a_cal_restart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && w0_wr |=> cal_r == fnd_pkg::CAL_RUN)
    else $error("word 0 write did not restart calibration");
  a_window_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ldw_code == 3'b000 |-> lock_window == 7'h64)
    else $error("lock window code 0 wrong");
  a_fb_pulse_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fb_pulse |=> !fb_pulse)
    else $error("feedback pulse longer than one cycle");
  a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && reg_rd && reg_addr == fnd_pkg::ADDR_W1 && !reg_wr
    |=> reg_rdata == $past(w1_r))
    else $error("word 1 readback wrong");
  a_out_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && reg_wr && reg_addr == fnd_pkg::ADDR_W4
    |=> primary_rf_output == $past(reg_wdata[fnd_pkg::PRI_EN_BIT]))
    else $error("primary enable not taken");
  a_band_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    band_r != 2'b11)
    else $error("band outside three");
  a_no_half_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ref_pulse |=> !ref_pulse)
    else $error("comparison pulse too long");
  c_cal_done: cover property (@(posedge sys_clk) cal_r == fnd_pkg::CAL_DONE);
  c_carry: cover property (@(posedge sys_clk) fb_pulse && carry);
  c_band_clk: cover property (@(posedge sys_clk) band_clk);
endmodule
`default_nettype wire

// [testbench/fnd_osc_model.sv]
// Behavioural reference oscillator and feedback source for the divider
`timescale 1ns/100ps
`default_nettype none
module fnd_osc_model (
  // Clock
  input wire logic sys_clk,
  // Half periods in sys_clk cycles, two or more
  input wire logic [3:0] ref_half,
  input wire logic [3:0] fb_half,
  // Link signals
  output logic ref_in,
  output logic vco_fb
);
  logic [3:0] ref_cnt = 4'h0;
  logic [3:0] fb_cnt = 4'h0;
  initial begin
    ref_in = 1'b0;
    vco_fb = 1'b0;
  end
  // A slow reference keeps the comparison rate far inside its limit
  always @(posedge sys_clk) begin
    if (ref_cnt + 4'h1 >= ref_half) begin
      ref_cnt <= 4'h0;
      ref_in <= ~ref_in;
    end else begin
      ref_cnt <= ref_cnt + 4'h1;
    end
    if (fb_cnt + 4'h1 >= fb_half) begin
      fb_cnt <= 4'h0;
      vco_fb <= ~vco_fb;
    end else begin
      fb_cnt <= fb_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the fractional-N feedback divider
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] ref_half = 4'h3;
  logic [3:0] fb_half = 4'h2;
  logic [31:0] reg_rdata;
  logic ref_in, vco_fb, ref_pulse, fb_pulse, band_clk, cal_busy;
  logic primary_rf_output, auxiliary_rf_output;
  logic [1:0] vco_band;
  logic [6:0] lock_window;
  logic ref_q = 1'b0;
  logic fb_q = 1'b0;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int cnt [0:3] = '{0, 0, 0, 0};
  always #20 sys_clk = ~sys_clk;
  fnd_osc_model osc (.sys_clk(sys_clk), .ref_half(ref_half),
    .fb_half(fb_half), .ref_in(ref_in), .vco_fb(vco_fb));
  fnd_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_in(ref_in),
    .vco_fb(vco_fb), .ref_dbl_edge(1'b0), .ref_pulse(ref_pulse),
    .fb_pulse(fb_pulse), .band_clk(band_clk), .vco_band(vco_band),
    .cal_busy(cal_busy), .lock_window(lock_window),
    .primary_rf_output(primary_rf_output),
    .auxiliary_rf_output(auxiliary_rf_output));
  // Event counters: ref rises, ref edges, feedback rises, ref pulses
  always @(posedge sys_clk) begin
    ref_q <= ref_in;
    fb_q <= vco_fb;
    if (ref_in && !ref_q) cnt[0] <= cnt[0] + 1;
    if (ref_in !== ref_q) cnt[1] <= cnt[1] + 1;
    if (vco_fb && !fb_q) cnt[2] <= cnt[2] + 1;
    if (ref_pulse === 1'b1) cnt[3] <= cnt[3] + 1;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      $display("Run exceeded its cycle budget");
      miscompares++;
      results();
    end
  end
  task results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp,
           input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [31:0] exp, input string w);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(w, exp, reg_rdata);
  endtask
  // Waits for the chosen pulse; bounded so a dead divider cannot hang
  task wait_p(input int sel);
    int k;
    logic p;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
      p = (sel == 2) ? fb_pulse : (sel == 3) ? band_clk : ref_pulse;
    end while (p !== 1'b1 && k < 3000);
    if (k >= 3000) chk("pulse wait", 32'h1, 32'h0);
  endtask
  task gap(input int sel, input int n, output int d);
    int c0;
    wait_p(sel);
    wait_p(sel);
    c0 = cnt[sel == 3 ? 3 : sel];
    repeat (n) wait_p(sel);
    d = cnt[sel == 3 ? 3 : sel] - c0;
  endtask
  task wait_cal(input logic v, input int lim);
    int k;
    k = 0;
    while (cal_busy !== v && k < lim) begin
      @(posedge sys_clk);
      #1 k++;
    end
    chk("cal_busy", 32'(v), 32'(cal_busy));
  endtask
  task t_reset;
    chk("cal_busy at reset", 32'h1, 32'(cal_busy));
    rd(fnd_pkg::ADDR_W0, fnd_pkg::RST_W0, "word0");
    rd(fnd_pkg::ADDR_W1, fnd_pkg::RST_W1, "word1");
    rd(fnd_pkg::ADDR_W2, fnd_pkg::RST_W2, "word2");
    rd(fnd_pkg::ADDR_W4, fnd_pkg::RST_W4, "word4");
    rd(3'h5, 32'h0, "unmapped");
    rd(fnd_pkg::ADDR_W7, 32'h0, "word7");
    chk("primary", 32'h1, 32'(primary_rf_output));
    chk("aux", 32'h0, 32'(auxiliary_rf_output));
    $display("test reset done");
  endtask
  task t_cal;
    wait_cal(1'b0, 6000);
    chk("band range", 32'h1, 32'(vco_band !== 2'h3));
    chk("band after cal", 32'(fnd_pkg::CAL_STEPS - 1), 32'(vco_band));
    rd(3'h3, 32'(fnd_pkg::CAL_STEPS - 1), "cal status");
    wr(fnd_pkg::ADDR_W0, fnd_pkg::RST_W0);
    wait_cal(1'b1, 4);
    wait_cal(1'b0, 6000);
    $display("test calibration done");
  endtask
  task t_lock;
    logic [6:0] tab [0:6];
    tab = '{7'h64, 7'h3C, 7'h1E, 7'h1E, 7'h28, 7'h2D, 7'h0F};
    for (int c = 0; c < 7; c++) begin
      wr(fnd_pkg::ADDR_W6, 32'(c >> 1) << 26);
      wr(fnd_pkg::ADDR_W2, fnd_pkg::RST_W2 | (32'(c & 1) << 7));
      #1 chk("lock window", 32'(tab[c]), 32'(lock_window));
    end
    wr(fnd_pkg::ADDR_W6, 32'h0);
    wr(fnd_pkg::ADDR_W2, fnd_pkg::RST_W2);
    $display("test lock window done");
  endtask
  task t_out;
    for (int b = 0; b < 4; b++) begin
      wr(fnd_pkg::ADDR_W4, (fnd_pkg::RST_W4 & ~32'h60) | (32'(b) << 5));
      #1 chk("primary", 32'(b & 1), 32'(primary_rf_output));
      chk("aux", 32'(b >> 1), 32'(auxiliary_rf_output));
    end
    wr(fnd_pkg::ADDR_W4, fnd_pkg::RST_W4);
    $display("test outputs done");
  endtask
  // Over one modulus of periods the rises equal FRACTION_MODULUS*INT+FRAC
  task t_div;
    int iv [0:4] = '{5, 4, 4, 3, 4};
    int fv [0:4] = '{0, 1, 2, 4, 2};
    int mv [0:4] = '{2, 2, 3, 5, 3};
    int d;
    logic [31:0] w0;
    for (int i = 0; i < 5; i++) begin
      fb_half <= (i == 3) ? 4'h3 : 4'h2;
      wr(fnd_pkg::ADDR_W7, (i == 4) ? 32'h100 : 32'h0);
      wr(fnd_pkg::ADDR_W1, 32'(mv[i]) << 3);
      w0 = (32'(iv[i]) << 15) | (32'(fv[i]) << 3);
      wr(fnd_pkg::ADDR_W0, w0);
      rd(fnd_pkg::ADDR_W0, w0, "word0 back");
      gap(2, mv[i], d);
      chk("fb rises", 32'(mv[i] * iv[i] + fv[i]), 32'(d));
    end
    fb_half <= 4'h2;
    wr(fnd_pkg::ADDR_W7, 32'h0);
    $display("test feedback divider done");
  endtask
  task t_ref;
    int sv [0:2] = '{0, 0, 1};
    int ev [0:2] = '{3, 6, 3};
    int d;
    for (int i = 0; i < 3; i++) begin
      wr(fnd_pkg::ADDR_W2, (32'h3 << 14) | (32'(i) << 24));
      gap(sv[i], 1, d);
      chk("ref events", 32'(ev[i]), 32'(d));
    end
    wr(fnd_pkg::ADDR_W2, fnd_pkg::RST_W2);
    $display("test reference path done");
  endtask
  task t_band;
    int d;
    wr(fnd_pkg::ADDR_W4, (fnd_pkg::RST_W4 & 32'hFFF00FFF) | 32'h2000);
    wr(fnd_pkg::ADDR_W6, 32'h8);
    gap(3, 1, d);
    chk("band divide", 32'd258, 32'(d));
    wr(fnd_pkg::ADDR_W6, 32'h0);
    wr(fnd_pkg::ADDR_W4, fnd_pkg::RST_W4);
    $display("test band divider done");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1 t_reset;
    t_cal;
    t_lock;
    t_out;
    t_div;
    t_ref;
    t_band;
    results;
  end
endmodule
`default_nettype wire
